// ---- design/ftir_pkg.sv ----
// Package with constants, states and carriers for the identification read state machine.
package ftir_pkg;

    // Command and address codes seen on the host link.
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
    localparam logic [7:0] CMD_UNIQUE_ID = 8'hED;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] ADDR_ID_STD = 8'h00;
    localparam logic [7:0] ADDR_ID_SIG = 8'h20;
    localparam logic [7:0] ADDR_LOAD = 8'h00;

    // Reset values of target-level registers.
    localparam logic [7:0] LAST_CMD_RESET = 8'h00;

    // Signature length in bytes and the last index that walks it.
    localparam int SIG_LEN = 4;
    localparam logic [1:0] SIG_LAST_IDX = 2'h3;

    // Default number of logical units and unit address width.
    localparam int UNIT_COUNT = 2;
    localparam int UNIT_AW = 1;

    // Target states, one-hot.
    typedef enum logic [10:0] {
        ST_IDLE        = 11'h001,
        ST_ID_ADDR     = 11'h002,
        ST_ID_STD_WAIT = 11'h004,
        ST_ID_MFR      = 11'h008,
        ST_ID_SIG_WAIT = 11'h010,
        ST_PP_ADDR     = 11'h020,
        ST_PP_LOAD     = 11'h040,
        ST_UID_ADDR    = 11'h080,
        ST_UID_LOAD    = 11'h100,
        ST_IDLE_RD     = 11'h200,
        ST_STATUS      = 11'h400
    } ftir_state_e;

    // One host link cycle: command, address or read-byte request.
    typedef struct packed {
        logic cmd_valid;
        logic addr_valid;
        logic rd_req;
        logic [7:0] value;
    } ftir_link_s;

    // Requests from the target to the logical units.
    typedef struct packed {
        logic invalidate_all;
        logic clear_ready;
        logic set_ready;
        logic load_param;
        logic load_uid;
    } ftir_unit_req_s;

endpackage : ftir_pkg

// ---- design/ftir_target.sv ----
// Target-level state machine for identification, parameter page and unique ID reads.
`timescale 1ns/1ns
module ftir_target
    import ftir_pkg::*;
#(
    parameter int UNITS = UNIT_COUNT,                 // Number of logical units.
    parameter int UAW = UNIT_AW,                      // Unit address width.
    parameter logic [7:0] MFR_CODE = 8'h5A,           // Arbitrary manufacturer code.
    parameter logic [7:0] DEV_CODE = 8'hA5,           // Arbitrary device code.
    parameter logic [31:0] SIGNATURE = 32'hB4D2E17C,  // Arbitrary signature bytes, first byte in low lane.
    parameter logic [7:0] VENDOR_FILL = 8'h00         // Value returned where content is undefined.
) (
    input wire logic clk_i,                           // 250 MHz clock.
    input wire logic reset_i,                         // Synchronous reset, active high.
    input wire logic clk_en_i,                        // Freezes all state while low.
    input wire ftir_link_s link_i,                    // Host command, address and read cycles.
    input wire logic status_output_flag_i,            // Status output mode flag.
    input wire logic [UAW-1:0] unit_choice_i,         // Unit chosen to serve a load.
    input wire logic unit_data_ready_i,               // Selected unit has data in its page register.
    input wire logic status_done_i,                   // Status read execution finished.
    output logic [7:0] read_data_o,                   // Byte returned on a read request.
    output logic read_valid_o,                        // Read data valid, one-cycle pulse.
    output logic ready_busy_n_o,                      // Ready high, busy low.
    output ftir_unit_req_s unit_req_o,                // One-cycle requests to units.
    output logic [UAW-1:0] selected_unit_o,           // Unit serving the load.
    output logic [7:0] last_command_reg_o,            // Last command code accepted.
    output logic column_change_allowed_o,             // Column change permitted.
    output logic enhanced_column_change_allowed_o,    // Enhanced column change permitted.
    output logic cmd_decode_o,                        // Command handed to general decode, pulse.
    output logic status_exec_o,                       // Status read execution active.
    output ftir_state_e return_state_o,               // State to resume after status read.
    output ftir_state_e state_o                       // Current state.
);

    ////////////////////////////////////////////////////////////////////////////////
    // State carrier.

    // All registered state of the target lives in one packed struct.
    typedef struct packed {
        ftir_state_e state;
        ftir_state_e ret;
        logic [1:0] sig_idx;
        logic id_dev_done;
        logic [7:0] rdata;
        logic rvalid;
        logic rb_n;
        ftir_unit_req_s req;
        logic [UAW-1:0] unit;
        logic [7:0] last_cmd;
        logic chg_col;
        logic chg_col_enh;
        logic decode;
    } ftir_regs_s;

    ftir_regs_s cur_ff;    // Registered state.
    ftir_regs_s nxt_cur;   // Next value of the state.

    // Returns one signature byte by index; low lane goes out first.
    function automatic logic [7:0] sig_byte(input logic [1:0] idx);
        sig_byte = SIGNATURE[{idx, 3'h0} +: 8];
    endfunction : sig_byte

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Commands are decoded in idle, idle-read and the identification read-wait states; a load state only
    // reacts to status reads, so a stray command cannot abort a unit load.
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rvalid = 1'b0;
        nxt_cur.req = '0;
        nxt_cur.decode = 1'b0;
        unique case (cur_ff.state)
            ST_IDLE, ST_IDLE_RD: begin
                // Idle-read answers stray reads with filler data.
                if (link_i.rd_req && cur_ff.state == ST_IDLE_RD) begin
                    nxt_cur.rdata = VENDOR_FILL;
                    nxt_cur.rvalid = 1'b1;
                end
                if (link_i.cmd_valid) begin
                    if (link_i.value == CMD_READ_ID) begin
                        nxt_cur.last_cmd = CMD_READ_ID;
                        nxt_cur.chg_col = 1'b0;
                        nxt_cur.chg_col_enh = 1'b0;
                        nxt_cur.req.invalidate_all = 1'b1;
                        nxt_cur.state = ST_ID_ADDR;
                    end else if (link_i.value == CMD_PARAM_PAGE) begin
                        nxt_cur.last_cmd = CMD_PARAM_PAGE;
                        nxt_cur.chg_col = 1'b1;
                        nxt_cur.chg_col_enh = 1'b0;
                        nxt_cur.req.invalidate_all = 1'b1;
                        nxt_cur.unit = unit_choice_i;
                        nxt_cur.state = ST_PP_ADDR;
                    end else if (link_i.value == CMD_UNIQUE_ID) begin
                        nxt_cur.last_cmd = CMD_UNIQUE_ID;
                        nxt_cur.chg_col = 1'b1;
                        nxt_cur.chg_col_enh = 1'b0;
                        nxt_cur.req.invalidate_all = 1'b1;
                        nxt_cur.unit = unit_choice_i;
                        nxt_cur.state = ST_UID_ADDR;
                    end else begin
                        nxt_cur.decode = 1'b1;
                    end
                end
            end
            ST_ID_ADDR: begin
                // Any other address is not served here and falls back to idle.
                if (link_i.addr_valid) begin
                    nxt_cur.id_dev_done = 1'b0;
                    nxt_cur.sig_idx = 2'h0;
                    if (link_i.value == ADDR_ID_STD) begin
                        nxt_cur.state = ST_ID_STD_WAIT;
                    end else if (link_i.value == ADDR_ID_SIG) begin
                        nxt_cur.state = ST_ID_SIG_WAIT;
                    end else begin
                        nxt_cur.state = ST_IDLE;
                    end
                end
            end
            ST_ID_STD_WAIT: begin
                if (link_i.cmd_valid) begin
                    nxt_cur.decode = 1'b1;
                    nxt_cur.state = ST_IDLE;
                end else if (link_i.rd_req) begin
                    nxt_cur.rdata = MFR_CODE;
                    nxt_cur.rvalid = 1'b1;
                    nxt_cur.state = ST_ID_MFR;
                end
            end
            ST_ID_MFR: begin
                if (link_i.cmd_valid) begin
                    nxt_cur.decode = 1'b1;
                    nxt_cur.state = ST_IDLE;
                end else if (link_i.rd_req) begin
                    nxt_cur.rdata = DEV_CODE;
                    nxt_cur.rvalid = 1'b1;
                    nxt_cur.id_dev_done = 1'b1;
                    nxt_cur.state = ST_IDLE_RD;
                end
            end
            ST_ID_SIG_WAIT: begin
                if (link_i.cmd_valid) begin
                    nxt_cur.decode = 1'b1;
                    nxt_cur.state = ST_IDLE;
                end else if (link_i.rd_req) begin
                    nxt_cur.rdata = sig_byte(cur_ff.sig_idx);
                    nxt_cur.rvalid = 1'b1;
                    nxt_cur.sig_idx = cur_ff.sig_idx + 2'h1;
                    if (cur_ff.sig_idx == SIG_LAST_IDX) begin
                        nxt_cur.state = ST_IDLE_RD;
                    end
                end
            end
            ST_PP_ADDR, ST_UID_ADDR: begin
                // The host is expected to send address 00h here.
                if (link_i.addr_valid && link_i.value == ADDR_LOAD) begin
                    nxt_cur.req.clear_ready = 1'b1;
                    nxt_cur.rb_n = 1'b0;
                    if (cur_ff.state == ST_PP_ADDR) begin
                        nxt_cur.req.load_param = 1'b1;
                        nxt_cur.ret = ST_PP_LOAD;
                        nxt_cur.state = ST_PP_LOAD;
                    end else begin
                        nxt_cur.req.load_uid = 1'b1;
                        nxt_cur.ret = ST_UID_LOAD;
                        nxt_cur.state = ST_UID_LOAD;
                    end
                end
            end
            ST_PP_LOAD, ST_UID_LOAD: begin
                if (unit_data_ready_i) begin
                    nxt_cur.req.set_ready = 1'b1;
                    nxt_cur.rb_n = 1'b1;
                    nxt_cur.state = ST_IDLE_RD;
                end else if (link_i.cmd_valid && link_i.value == CMD_READ_STATUS) begin
                    nxt_cur.state = ST_STATUS;
                end else if (link_i.rd_req && status_output_flag_i) begin
                    nxt_cur.state = ST_IDLE_RD;
                end
            end
            ST_STATUS: begin
                // Resume the interrupted load once status execution ends.
                if (status_done_i) begin
                    nxt_cur.state = cur_ff.ret;
                end
            end
            default: begin
                nxt_cur.state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // Clock enable freezes everything, including the one-cycle pulses.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cur_ff <= '{state: ST_IDLE, ret: ST_IDLE, sig_idx: 2'h0, id_dev_done: 1'b0,
                        rdata: 8'h00, rvalid: 1'b0, rb_n: 1'b1, req: '0, unit: '0,
                        last_cmd: LAST_CMD_RESET, chg_col: 1'b0, chg_col_enh: 1'b0,
                        decode: 1'b0};
        end else if (clk_en_i) begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs come straight from the state register.
    assign read_data_o = cur_ff.rdata;
    assign read_valid_o = cur_ff.rvalid;
    assign ready_busy_n_o = cur_ff.rb_n;
    assign unit_req_o = cur_ff.req;
    assign selected_unit_o = cur_ff.unit;
    assign last_command_reg_o = cur_ff.last_cmd;
    assign column_change_allowed_o = cur_ff.chg_col;
    assign enhanced_column_change_allowed_o = cur_ff.chg_col_enh;
    assign cmd_decode_o = cur_ff.decode;
    assign status_exec_o = (cur_ff.state == ST_STATUS);
    assign return_state_o = cur_ff.ret;
    assign state_o = cur_ff.state;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    // All checks run on the target clock and stay quiet while reset is held.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // A first read after address 00h returns the manufacturer byte in the next cycle.
    chk_mfr_byte_out: assert property (
        clk_en_i && cur_ff.state == ST_ID_STD_WAIT && !link_i.cmd_valid && link_i.rd_req
        |=> read_valid_o && read_data_o == MFR_CODE) else $error("manufacturer byte wrong");

    // The second read returns the device byte and always lands in idle-read.
    chk_dev_to_idle: assert property (
        clk_en_i && cur_ff.state == ST_ID_MFR && !link_i.cmd_valid && link_i.rd_req
        |=> read_data_o == DEV_CODE && state_o == ST_IDLE_RD) else $error("device byte wrong");

    // Each signature read returns the byte picked by the index held before the read.
    chk_sig_walk: assert property (
        clk_en_i && cur_ff.state == ST_ID_SIG_WAIT && !link_i.cmd_valid && link_i.rd_req
        |=> read_data_o == sig_byte($past(cur_ff.sig_idx))) else $error("signature byte wrong");

    // The parameter page command records its code, sets the column change flag, clears the enhanced one and invalidates pages.
    chk_pp_flags: assert property (
        clk_en_i && cur_ff.state == ST_IDLE && link_i.cmd_valid && link_i.value == CMD_PARAM_PAGE
        |=> last_command_reg_o == CMD_PARAM_PAGE && column_change_allowed_o && !enhanced_column_change_allowed_o
        && unit_req_o.invalidate_all) else $error("param flags wrong");

    // The parameter page command latches the unit that serves it and waits for its address.
    chk_pp_select: assert property (
        clk_en_i && cur_ff.state == ST_IDLE && link_i.cmd_valid && link_i.value == CMD_PARAM_PAGE
        |=> selected_unit_o == $past(unit_choice_i) && state_o == ST_PP_ADDR) else $error("param unit wrong");

    // The unique ID command latches the serving unit and records its code.
    chk_uid_select: assert property (
        clk_en_i && cur_ff.state == ST_IDLE && link_i.cmd_valid && link_i.value == CMD_UNIQUE_ID
        |=> selected_unit_o == $past(unit_choice_i) && last_command_reg_o == CMD_UNIQUE_ID)
        else $error("unique unit wrong");

    // Entering a load from its address wait drops ready/busy and asks the unit to clear its ready bit.
    chk_load_busy: assert property (
        $rose(state_o == ST_PP_LOAD || state_o == ST_UID_LOAD) && $past(state_o) != ST_STATUS
        |-> !ready_busy_n_o && unit_req_o.clear_ready) else $error("load start wrong");

    // A status command during a load diverts to status execution and keeps the load to resume.
    chk_status_divert: assert property (
        clk_en_i && (cur_ff.state == ST_PP_LOAD || cur_ff.state == ST_UID_LOAD) && !unit_data_ready_i
        && link_i.cmd_valid && link_i.value == CMD_READ_STATUS
        |=> status_exec_o && return_state_o == $past(state_o)) else $error("status divert wrong");

    // Once the unit reports data, the load ends with ready released and the ready bit set.
    chk_load_done: assert property (
        clk_en_i && (cur_ff.state == ST_PP_LOAD || cur_ff.state == ST_UID_LOAD) && unit_data_ready_i
        |=> ready_busy_n_o && unit_req_o.set_ready && state_o == ST_IDLE_RD) else $error("load end wrong");

    // A read with the status flag set during either load goes to idle-read and returns no data.
    chk_status_idle: assert property (
        clk_en_i && (cur_ff.state == ST_PP_LOAD || cur_ff.state == ST_UID_LOAD) && !unit_data_ready_i
        && !link_i.cmd_valid && link_i.rd_req && status_output_flag_i
        |=> state_o == ST_IDLE_RD && !read_valid_o) else $error("status idle wrong");

    // Main scenarios: standard read, full signature walk, status detour and unique ID completion.
    cov_id_std: cover property (state_o == ST_ID_MFR ##[1:20] state_o == ST_IDLE_RD);
    cov_sig_all: cover property (state_o == ST_ID_SIG_WAIT ##[1:40] state_o == ST_IDLE_RD);
    cov_pp_status: cover property (state_o == ST_PP_LOAD ##1 state_o == ST_STATUS ##[1:40] state_o == ST_PP_LOAD);
    cov_uid_done: cover property (state_o == ST_UID_LOAD ##[1:40] state_o == ST_IDLE_RD && ready_busy_n_o);

endmodule : ftir_target

// ---- dv/ftir_target_bench.sv ----
// Self-checking testbench for the identification read state machine.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module ftir_target_bench;
    import ftir_pkg::*;
    localparam logic [7:0] MFR = 8'h3C;        // Arbitrary manufacturer code.
    localparam logic [7:0] DEV = 8'hC3;        // Arbitrary device code.
    localparam logic [31:0] SIG = 32'h44332211; // Arbitrary signature, first byte low.
    logic clk, rst, sflag, udr, sdone, rvalid, rbn, chg, enh, cdec, sexec, cen;
    logic [0:0] uchoice, selu;
    logic [7:0] rdata, lastc, delay;
    ftir_link_s link;
    ftir_unit_req_s ureq;
    ftir_state_e rstate, state;
    int error_cnt, tests_run;

    ftir_target #(.MFR_CODE(MFR), .DEV_CODE(DEV), .SIGNATURE(SIG)) i_dut (
        .clk_i(clk), .reset_i(rst), .clk_en_i(cen), .link_i(link), .status_output_flag_i(sflag),
        .unit_choice_i(uchoice), .unit_data_ready_i(udr), .status_done_i(sdone), .read_data_o(rdata),
        .read_valid_o(rvalid), .ready_busy_n_o(rbn), .unit_req_o(ureq), .selected_unit_o(selu),
        .last_command_reg_o(lastc), .column_change_allowed_o(chg), .enhanced_column_change_allowed_o(enh),
        .cmd_decode_o(cdec), .status_exec_o(sexec), .return_state_o(rstate), .state_o(state));
    ftir_unit_model i_unit (.clk_i(clk), .reset_i(rst), .unit_req_i(ureq), .delay_i(delay), .data_ready_o(udr));

    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock at 250 MHz.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compare tasks, one per kind of result; a mismatch is counted and shown at once.
    task chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk8
    task chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask : chk1
    task chks(input logic [10:0] g, input logic [10:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chks

    // One link cycle, entered at a falling edge; the registered answer is settled on return.
    // The link is assigned once per step, so back-to-back cycles never glitch the flags.
    task cyc(input logic c, input logic a, input logic r, input logic [7:0] v);
        link = '{c, a, r, v};
        @(negedge clk);
    endtask : cyc

    // Two-cycle reset so every scenario starts from the idle state.
    task restart();
        rst = 1'b1;
        cyc(1'b0, 1'b0, 1'b0, 8'h00);
        cyc(1'b0, 1'b0, 1'b0, 8'h00);
        rst = 1'b0;
    endtask : restart

    // Wait a bounded time for the load to finish, then check the completion step.
    task wait_ready();
        int n;
        n = 0;
        while (rbn !== 1'b1 && n < 200) begin
            cyc(1'b0, 1'b0, 1'b0, 8'h00);
            n++;
        end
        chk1(rbn, 1'b1);
        chk1(ureq.set_ready, 1'b1);
        chks(state, ST_IDLE_RD);
    endtask : wait_ready

    task summarize();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        #40000;
        error_cnt++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        link = '0;
        rst = 1'b1;
        cen = 1'b1;
        sflag = 1'b0;
        uchoice = 1'b0;
        sdone = 1'b0;
        delay = 8'h01;
        error_cnt = 0;
        tests_run = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chks(state, ST_IDLE);
        chk1(rbn, 1'b1);
        chk8(lastc, LAST_CMD_RESET);
        // Standard identification: manufacturer then device code, back to back.
        cyc(1'b1, 1'b0, 1'b0, CMD_READ_ID);
        cyc(1'b0, 1'b1, 1'b0, ADDR_ID_STD);
        cyc(1'b0, 1'b0, 1'b1, 8'h00);
        chk1(rvalid, 1'b1);
        chk8(rdata, MFR);
        // A low clock enable swallows the read and holds the manufacturer byte and its pulse.
        cen = 1'b0;
        cyc(1'b0, 1'b0, 1'b1, 8'h00);
        cen = 1'b1;
        chk1(rvalid, 1'b1);
        chks(state, ST_ID_MFR);
        cyc(1'b0, 1'b0, 1'b1, 8'h00);
        chk8(rdata, DEV);
        chks(state, ST_IDLE_RD);
        // A command while waiting for the first read goes to general decode.
        restart();
        cyc(1'b1, 1'b0, 1'b0, CMD_READ_ID);
        cyc(1'b0, 1'b1, 1'b0, ADDR_ID_STD);
        cyc(1'b1, 1'b0, 1'b0, 8'h30);
        chk1(cdec, 1'b1);
        // A command after the manufacturer byte also goes to decode.
        restart();
        cyc(1'b1, 1'b0, 1'b0, CMD_READ_ID);
        cyc(1'b0, 1'b1, 1'b0, ADDR_ID_STD);
        cyc(1'b0, 1'b0, 1'b1, 8'h00);
        cyc(1'b1, 1'b0, 1'b0, 8'h30);
        chk1(cdec, 1'b1);
        // Signature walk of four bytes, low lane first; bytes past four are not checked.
        restart();
        cyc(1'b1, 1'b0, 1'b0, CMD_READ_ID);
        cyc(1'b0, 1'b1, 1'b0, ADDR_ID_SIG);
        for (int i = 0; i < SIG_LEN; i++) begin
            cyc(1'b0, 1'b0, 1'b1, 8'h00);
            chk8(rdata, SIG[8*i +: 8]);
            chks(state, (i == SIG_LEN - 1) ? ST_IDLE_RD : ST_ID_SIG_WAIT);
        end
        // Parameter page with a prompt unit on unit one.
        restart();
        uchoice = 1'b1;
        cyc(1'b1, 1'b0, 1'b0, CMD_PARAM_PAGE);
        chk8(lastc, CMD_PARAM_PAGE);
        chk1(chg, 1'b1);
        chk1(enh, 1'b0);
        chk1(ureq.invalidate_all, 1'b1);
        chk8({7'h00, selu}, 8'h01);
        cyc(1'b0, 1'b1, 1'b0, 8'h01);
        chks(state, ST_PP_ADDR);
        cyc(1'b0, 1'b1, 1'b0, ADDR_LOAD);
        chk1(rbn, 1'b0);
        chk1(ureq.clear_ready, 1'b1);
        chk1(ureq.load_param, 1'b1);
        chks(rstate, ST_PP_LOAD);
        wait_ready();
        // Parameter page with a slow unit and a status read in the middle.
        restart();
        uchoice = 1'b0;
        delay = 8'h1E;
        cyc(1'b1, 1'b0, 1'b0, CMD_PARAM_PAGE);
        cyc(1'b0, 1'b1, 1'b0, ADDR_LOAD);
        cyc(1'b1, 1'b0, 1'b0, CMD_READ_STATUS);
        chk1(sexec, 1'b1);
        chks(state, ST_STATUS);
        sdone = 1'b1;
        cyc(1'b0, 1'b0, 1'b0, 8'h00);
        sdone = 1'b0;
        chks(state, ST_PP_LOAD);
        chk1(rbn, 1'b0);
        wait_ready();
        // Unique ID on unit one; the load must not end before the unit reports data.
        restart();
        uchoice = 1'b1;
        delay = 8'h0C;
        cyc(1'b1, 1'b0, 1'b0, CMD_UNIQUE_ID);
        chk8(lastc, CMD_UNIQUE_ID);
        chk1(chg, 1'b1);
        chk1(enh, 1'b0);
        chk1(ureq.invalidate_all, 1'b1);
        chk8({7'h00, selu}, 8'h01);
        cyc(1'b0, 1'b1, 1'b0, ADDR_LOAD);
        chk1(rbn, 1'b0);
        chk1(ureq.clear_ready, 1'b1);
        chk1(ureq.load_uid, 1'b1);
        chks(rstate, ST_UID_LOAD);
        repeat (8) cyc(1'b0, 1'b0, 1'b0, 8'h00);
        chks(state, ST_UID_LOAD);
        wait_ready();
        // Read request with the status flag set during a load moves to status idle, no data.
        restart();
        sflag = 1'b1;
        delay = 8'h1E;
        cyc(1'b1, 1'b0, 1'b0, CMD_PARAM_PAGE);
        cyc(1'b0, 1'b1, 1'b0, ADDR_LOAD);
        cyc(1'b0, 1'b0, 1'b1, 8'h00);
        chk1(rvalid, 1'b0);
        chks(state, ST_IDLE_RD);
        summarize();
    end
endmodule : ftir_target_bench

// ---- dv/ftir_unit_model.sv ----
// Behavioural logical unit that answers load requests after a programmable delay.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module ftir_unit_model
    import ftir_pkg::*;
(
    input wire logic clk_i,                  // Same clock as the target.
    input wire logic reset_i,                // Synchronous reset, active high.
    input wire ftir_unit_req_s unit_req_i,   // Requests from the target.
    input wire logic [7:0] delay_i,          // Load latency in cycles, one or more.
    output logic data_ready_o                // Page register holds the requested data.
);
    logic [7:0] cnt_ff; // Cycles left until the page data is present.

    // A new load restarts the count and drops readiness; invalidation also drops it.
    // A delay of zero is not supported, so the bench always passes one or more.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_ff <= 8'h00;
            data_ready_o <= 1'b0;
        end else if (unit_req_i.load_param || unit_req_i.load_uid) begin
            cnt_ff <= delay_i;
            data_ready_o <= 1'b0;
        end else if (unit_req_i.clear_ready || unit_req_i.invalidate_all) begin
            data_ready_o <= 1'b0;
        end else if (cnt_ff == 8'h01) begin
            cnt_ff <= 8'h00;
            data_ready_o <= 1'b1;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
endmodule : ftir_unit_model
